// ===== core/adc_ctl.sv
// Functional notes
// [RL1] Conversion starts on software start bit or any enabled trigger source.
// [RL2] Trigger select holds sixteen enables; bits 15..11 DMA, I2C, SPI interrupts.
// [RL3] Trigger bits 10..8 UART, 7..5 basic timers, 4..1 general timers.
// [RL4] Trigger bit 0 selects the advanced timer trigger output.
// [RL5] Watchdog compares only with global enable set and on chosen channel.
// [RL6] Result at or above high threshold sets the above-high flag.
// [RL7] Result below low threshold sets the below-low flag.
// [RL8] Result within [low, high) sets the in-range flag.
// [RL9] Watchdog flags request interrupt only when their enable bit is set.
// [RL10] Temperature sensor enable resets to 0; writing 1 turns it on.
// [RL11] Channel multiplexer value 0x0E routes temperature sensor to converter.
// [RL12] Mode 0 means single-channel single conversion.
// [RL13] Software waits for startup-done before configuring and starting.
// [RL14] Single conversion sets conversion-done flag and stores first result.
// [RL15] Seven interrupt sources, each with flag and same-position enable.
// [RL16] Enable bit 1 allows a flag's interrupt; 0 blocks it.
// [RL17] Writing 0 to a clear bit clears the flag; 1 leaves it.
// [RL18] All-done flag sets when multiple run reaches its programmed count.
// [RL19] Sequence-done flag sets when every selected sequence channel converted.
// [RL20] Follower enable 1 routes input through follower; 0 connects directly.
// [RL21] Any enabled trigger edge is one start request; disabled ones ignored.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module adc_ctl
   import adc_ctl_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic srst_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // Trigger sources
   input wire logic dma_irq_in,
   input wire logic [1:0] i2c_irq_in,
   input wire logic [1:0] spi_irq_in,
   input wire logic [2:0] uart_irq_in,
   input wire logic [2:0] basic_timer_irq_in,
   input wire logic [3:0] general_timer_irq_in,
   input wire logic advanced_timer_trig_in,
   // Converter core
   input wire logic core_ready_in,
   input wire conv_res_s core_res_in,
   output conv_ctl_s core_ctl_out,
   // Interrupt request
   output logic irq_out
);
   // Main control
   logic enable_ff;
   logic [2:0] mode_ff;
   logic temp_en_ff;
   logic follower_ff;
   // Second control
   logic [3:0] channel_multiplexer_ff;
   logic [3:0] wd_ch_ff;
   logic wd_all_ff;
   // Start, sequence and run setup
   logic start_ff;
   logic [15:0] seq_slots_ff;
   logic [1:0] seq_last_ff;
   logic [7:0] run_count_ff;
   logic [11:0] high_thr_ff;
   logic [11:0] low_thr_ff;
   logic [15:0] trig_sel_ff;
   // Status
   logic [11:0] result_ff;
   logic [FLAG_COUNT-1:0] int_en_ff;
   logic [FLAG_COUNT-1:0] flags_ff;
   logic ready_ff;
   // Sequencer
   conv_state_e state_ff;
   conv_state_e nxt_state;
   logic [1:0] slot_ff;
   logic [7:0] runs_ff;
   logic [3:0] cur_ch_ff;
   logic core_start_ff;

   // Decode
   logic wr_main, wr_second, wr_start, wr_seq, wr_run, wr_high, wr_low;
   logic wr_trig, wr_ien, wr_clear;
   assign wr_main = wr_in && (addr_in == OFS_MAIN_CONTROL);
   assign wr_second = wr_in && (addr_in == OFS_SECOND_CONTROL);
   assign wr_start = wr_in && (addr_in == OFS_START);
   assign wr_seq = wr_in && (addr_in == OFS_SEQUENCE);
   assign wr_run = wr_in && (addr_in == OFS_RUN_CONTROL);
   assign wr_high = wr_in && (addr_in == OFS_HIGH_THRESHOLD);
   assign wr_low = wr_in && (addr_in == OFS_LOW_THRESHOLD);
   assign wr_trig = wr_in && (addr_in == OFS_TRIGGER_SELECT);
   assign wr_ien = wr_in && (addr_in == OFS_INT_ENABLE);
   assign wr_clear = wr_in && (addr_in == OFS_INT_CLEAR);

   // Trigger sources in select-register bit order
   logic [TRIG_COUNT-1:0] trig_src;
   logic trig_fire;
   assign trig_src = {dma_irq_in, i2c_irq_in, spi_irq_in, // RL2
                      uart_irq_in, basic_timer_irq_in, general_timer_irq_in, // RL3
                      advanced_timer_trig_in}; // RL4

   trig_edge #(
      .W(TRIG_COUNT)
   ) u_trig_edge (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .level_in(trig_src),
      .mask_in(trig_sel_ff), // RL21
      .fire_out(trig_fire)
   );

   // Start decision
   logic sw_start, sw_stop, go, abort;
   assign sw_start = wr_start && wdata_in[START_BIT];
   assign sw_stop = wr_start && !wdata_in[START_BIT];
   // Gated on startup-done so an early start cannot reach a cold core
   assign go = (sw_start || trig_fire) && enable_ff && ready_ff // RL1 RL13
               && (state_ff == ST_IDLE);
   assign abort = (state_ff == ST_CONVERT) && (sw_stop || !enable_ff);

   // Result handling
   logic res_valid, wd_active, is_high, is_low, is_range;
   logic seq_mode, multi_mode, cont_mode, slot_last, seq_end, all_end;
   logic keep_going;
   logic [1:0] nxt_slot;
   logic [3:0] nxt_ch;
   logic [3:0] slot_ch;
   assign res_valid = core_res_in.valid && (state_ff == ST_CONVERT) && !abort;
   assign wd_active = wd_all_ff && (cur_ch_ff == wd_ch_ff); // RL5
   assign is_high = core_res_in.data >= high_thr_ff; // RL6
   assign is_low = core_res_in.data < low_thr_ff; // RL7
   assign is_range = !is_low && !is_high; // RL8
   // Mode 0 clears all three bits: one channel, one conversion
   assign seq_mode = mode_ff[0]; // RL12
   assign multi_mode = mode_ff[1];
   assign cont_mode = mode_ff[2];
   assign slot_last = !seq_mode || (slot_ff == seq_last_ff);
   assign seq_end = res_valid && seq_mode && slot_last; // RL19
   assign all_end = res_valid && multi_mode && (runs_ff == run_count_ff); // RL18
   assign keep_going = !all_end && ((seq_mode && !slot_last) || multi_mode || cont_mode);
   assign nxt_slot = slot_last ? 2'h0 : slot_ff + 2'h1;
   assign slot_ch = seq_slots_ff[{nxt_slot, 2'b00} +: 4];
   // Channel 0x0E selects the temperature sensor inside the core
   assign nxt_ch = seq_mode ? slot_ch : channel_multiplexer_ff; // RL11

   // Flag events and software clear
   logic [FLAG_COUNT-1:0] flag_set;
   logic [FLAG_COUNT-1:0] flag_clr;
   logic [FLAG_COUNT-1:0] nxt_flags;
   always_comb begin
      flag_set = '0;
      flag_set[FLG_CONV_DONE] = res_valid; // RL14
      flag_set[FLG_SEQ_DONE] = seq_end;
      flag_set[FLG_ALL_DONE] = all_end;
      flag_set[FLG_BELOW_LOW] = res_valid && wd_active && is_low; // RL7
      flag_set[FLG_ABOVE_HIGH] = res_valid && wd_active && is_high; // RL6
      flag_set[FLG_IN_RANGE] = res_valid && wd_active && is_range; // RL8
      // Overflow: a new result lands while the previous one is unacknowledged
      flag_set[FLG_OVERFLOW] = res_valid && flags_ff[FLG_CONV_DONE];
   end
   assign flag_clr = wr_clear ? ~wdata_in[FLAG_COUNT-1:0] : '0; // RL17
   // A set in the cycle of a clear still wins
   assign nxt_flags = (flags_ff & ~flag_clr) | flag_set; // RL15

   // Sequencer state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (go) begin
               nxt_state = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            if (abort || (res_valid && !keep_going)) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Read mux
   logic [31:0] rd_word;
   logic [31:0] ctl_word;
   logic [31:0] second_word;
   logic [31:0] status_word;
   always_comb begin
      ctl_word = READ_ZERO;
      ctl_word[CONV_ENABLE_BIT] = enable_ff;
      ctl_word[MODE_LSB +: 3] = mode_ff;
      ctl_word[TEMP_SENSOR_ENABLE_BIT] = temp_en_ff;
      ctl_word[FOLLOWER_ENABLE_BIT] = follower_ff;
      second_word = READ_ZERO;
      second_word[CHANNEL_MULTIPLEXER_LSB +: 4] = channel_multiplexer_ff;
      second_word[WATCHDOG_CHANNEL_LSB +: 4] = wd_ch_ff;
      second_word[WATCHDOG_GLOBAL_ENABLE_BIT] = wd_all_ff;
      status_word = READ_ZERO;
      status_word[FLAG_COUNT-1:0] = flags_ff;
      status_word[STARTUP_DONE_BIT] = ready_ff;
   end
   assign rd_word =
      (addr_in == OFS_MAIN_CONTROL) ? ctl_word :
      (addr_in == OFS_SECOND_CONTROL) ? second_word :
      (addr_in == OFS_START) ? {31'h0, start_ff} :
      (addr_in == OFS_SEQUENCE) ? {14'h0, seq_last_ff, seq_slots_ff} :
      (addr_in == OFS_RUN_CONTROL) ? {24'h0, run_count_ff} :
      (addr_in == OFS_HIGH_THRESHOLD) ? {20'h0, high_thr_ff} :
      (addr_in == OFS_LOW_THRESHOLD) ? {20'h0, low_thr_ff} :
      (addr_in == OFS_TRIGGER_SELECT) ? {16'h0, trig_sel_ff} :
      (addr_in == OFS_FIRST_RESULT) ? {20'h0, result_ff} :
      (addr_in == OFS_INT_ENABLE) ? {25'h0, int_en_ff} :
      (addr_in == OFS_INT_STATUS) ? status_word :
      READ_ZERO;

   // Configuration registers
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         enable_ff <= 1'b0;
         mode_ff <= MODE_SINGLE;
         temp_en_ff <= 1'b0;
         follower_ff <= 1'b0;
      end else if (wr_main) begin
         enable_ff <= wdata_in[CONV_ENABLE_BIT];
         mode_ff <= wdata_in[MODE_LSB +: 3];
         temp_en_ff <= wdata_in[TEMP_SENSOR_ENABLE_BIT]; // RL10
         follower_ff <= wdata_in[FOLLOWER_ENABLE_BIT]; // RL20
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         channel_multiplexer_ff <= 4'h0;
         wd_ch_ff <= 4'h0;
         wd_all_ff <= 1'b0;
      end else if (wr_second) begin
         channel_multiplexer_ff <= wdata_in[CHANNEL_MULTIPLEXER_LSB +: 4];
         wd_ch_ff <= wdata_in[WATCHDOG_CHANNEL_LSB +: 4];
         wd_all_ff <= wdata_in[WATCHDOG_GLOBAL_ENABLE_BIT];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         seq_slots_ff <= 16'h0000;
         seq_last_ff <= 2'h0;
      end else if (wr_seq) begin
         seq_slots_ff <= wdata_in[15:0];
         seq_last_ff <= wdata_in[SEQ_LAST_LSB +: 2];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         run_count_ff <= 8'h00;
      end else if (wr_run) begin
         run_count_ff <= wdata_in[RUN_COUNT_LSB +: 8];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         high_thr_ff <= HIGH_THRESHOLD_RESET;
         low_thr_ff <= LOW_THRESHOLD_RESET;
      end else begin
         if (wr_high) begin
            high_thr_ff <= wdata_in[11:0];
         end
         if (wr_low) begin
            low_thr_ff <= wdata_in[11:0];
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         trig_sel_ff <= TRIGGER_SELECT_RESET;
         int_en_ff <= '0;
      end else begin
         if (wr_trig) begin
            trig_sel_ff <= wdata_in[TRIG_COUNT-1:0]; // RL2
         end
         if (wr_ien) begin
            int_en_ff <= wdata_in[FLAG_COUNT-1:0]; // RL16
         end
      end
   end

   // Start bit reads 1 for the whole run and drops when it ends
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         start_ff <= 1'b0;
      end else if (go) begin
         start_ff <= 1'b1;
      end else if ((state_ff == ST_IDLE) || (nxt_state == ST_IDLE)) begin
         start_ff <= 1'b0;
      end
   end

   // Sequencer
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         state_ff <= ST_IDLE;
         slot_ff <= 2'h0;
         runs_ff <= 8'h00;
         cur_ch_ff <= 4'h0;
         core_start_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         core_start_ff <= go || (res_valid && keep_going); // RL1
         if (go) begin
            slot_ff <= 2'h0;
            runs_ff <= 8'h00;
            cur_ch_ff <= seq_mode ? seq_slots_ff[3:0] : channel_multiplexer_ff;
         end else if (res_valid) begin
            slot_ff <= nxt_slot;
            runs_ff <= runs_ff + 8'h01;
            cur_ch_ff <= nxt_ch;
         end
      end
   end

   // Status and result
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         flags_ff <= '0;
         result_ff <= 12'h000;
         ready_ff <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         flags_ff <= nxt_flags;
         ready_ff <= enable_ff && core_ready_in;
         irq_out <= |(nxt_flags & int_en_ff); // RL9 RL16
         if (res_valid) begin
            result_ff <= core_res_in.data; // RL14
         end
      end
   end

   // Register read data, valid only in the cycle after the strobe
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         rdata_out <= READ_ZERO;
      end else if (rd_in) begin
         rdata_out <= rd_word;
      end else begin
         rdata_out <= READ_ZERO;
      end
   end

   assign core_ctl_out.enable = enable_ff;
   assign core_ctl_out.start = core_start_ff;
   assign core_ctl_out.channel = cur_ch_ff;
   assign core_ctl_out.temp_sensor_on = temp_en_ff; // RL10
   assign core_ctl_out.follower_on = follower_ff; // RL20
endmodule // adc_ctl

// ===== core/adc_ctl_pkg.sv
package adc_ctl_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_MAIN_CONTROL = 8'h00;
   localparam logic [7:0] OFS_SECOND_CONTROL = 8'h04;
   localparam logic [7:0] OFS_START = 8'h08;
   localparam logic [7:0] OFS_SEQUENCE = 8'h0C;
   localparam logic [7:0] OFS_RUN_CONTROL = 8'h10;
   localparam logic [7:0] OFS_HIGH_THRESHOLD = 8'h14;
   localparam logic [7:0] OFS_LOW_THRESHOLD = 8'h18;
   localparam logic [7:0] OFS_TRIGGER_SELECT = 8'h1C;
   localparam logic [7:0] OFS_FIRST_RESULT = 8'h20;
   localparam logic [7:0] OFS_INT_ENABLE = 8'h34;
   localparam logic [7:0] OFS_INT_CLEAR = 8'h38;
   localparam logic [7:0] OFS_INT_STATUS = 8'h3C;
   // Main control fields
   localparam int CONV_ENABLE_BIT = 0;
   localparam int MODE_LSB = 1;
   localparam int TEMP_SENSOR_ENABLE_BIT = 5;
   localparam int FOLLOWER_ENABLE_BIT = 13;
   // Second control fields
   localparam int CHANNEL_MULTIPLEXER_LSB = 0;
   localparam int WATCHDOG_CHANNEL_LSB = 4;
   localparam int WATCHDOG_GLOBAL_ENABLE_BIT = 8;
   // Start register, sequence and run count fields
   localparam int START_BIT = 0;
   localparam int SEQ_LAST_LSB = 16;
   localparam int RUN_COUNT_LSB = 0;
   // Flag positions, shared by status, enable and clear registers
   localparam int FLAG_COUNT = 7;
   localparam int FLG_CONV_DONE = 0;
   localparam int FLG_SEQ_DONE = 1;
   localparam int FLG_ALL_DONE = 2;
   localparam int FLG_BELOW_LOW = 3;
   localparam int FLG_ABOVE_HIGH = 4;
   localparam int FLG_IN_RANGE = 5;
   localparam int FLG_OVERFLOW = 6;
   localparam int STARTUP_DONE_BIT = 7;
   // Encodings and reset values
   localparam int TRIG_COUNT = 16;
   localparam logic [3:0] TEMP_SENSOR_CHANNEL = 4'hE;
   localparam logic [2:0] MODE_SINGLE = 3'h0;
   localparam logic [11:0] RESULT_MAX = 12'hFFF;
   localparam logic [11:0] HIGH_THRESHOLD_RESET = 12'hFFF;
   localparam logic [11:0] LOW_THRESHOLD_RESET = 12'h000;
   localparam logic [15:0] TRIGGER_SELECT_RESET = 16'h0000;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONVERT = 2'b01
   } conv_state_e;

   // Controls towards the converter core
   typedef struct packed {
      logic enable;
      logic start;
      logic [3:0] channel;
      logic temp_sensor_on;
      logic follower_on;
   } conv_ctl_s;

   // Result coming back from the converter core
   typedef struct packed {
      logic valid;
      logic [11:0] data;
   } conv_res_s;
endpackage

// ===== core/trig_edge.sv
`timescale 1ns/1ps
module trig_edge #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic srst_in,
   // Sources and their enables
   input wire logic [W-1:0] level_in,
   input wire logic [W-1:0] mask_in,
   // One-cycle start request
   output logic fire_out
);
   logic [W-1:0] prev_ff;
   logic [W-1:0] gated;

   // Masking before the edge detect keeps disabled sources silent
   assign gated = level_in & mask_in;

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         prev_ff <= '0;
         fire_out <= 1'b0;
      end else begin
         prev_ff <= gated;
         fire_out <= |(gated & ~prev_ff);
      end
   end
endmodule // trig_edge

// ===== verif/adc_ctl_chk.sv
`timescale 1ns/1ps
module adc_ctl_chk
   import adc_ctl_pkg::*;
(
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic dma_irq_in,
   input wire logic [1:0] i2c_irq_in,
   input wire logic [1:0] spi_irq_in,
   input wire logic [2:0] uart_irq_in,
   input wire logic [2:0] basic_timer_irq_in,
   input wire logic [3:0] general_timer_irq_in,
   input wire logic advanced_timer_trig_in,
   input wire logic core_ready_in,
   input wire conv_res_s core_res_in,
   input wire conv_ctl_s core_ctl_out,
   input wire logic irq_out
);
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (srst_in);
   wire [15:0] trg_w = {dma_irq_in, i2c_irq_in, spi_irq_in, uart_irq_in,
      basic_timer_irq_in, general_timer_irq_in, advanced_timer_trig_in};
   wire wr_main = wr_in && addr_in == OFS_MAIN_CONTROL;
   wire wr_ie = wr_in && addr_in == OFS_INT_ENABLE;
   wire sw_go = wr_in && addr_in == OFS_START && wdata_in[START_BIT];
   wire clr_all = wr_in && addr_in == OFS_INT_CLEAR && wdata_in[6:0] == 7'h00;
   logic [15:0] sel_ff, tsel_ff;
   logic [31:0] main_ff, sec_ff;
   logic [6:0] ie_ff;
   logic busy_ff, rdy_ff;
   logic [2:0] age_ff;
   // Enabling a select bit on a high source counts as an edge
   wire trg_rise = |(trg_w & sel_ff & ~tsel_ff);
   wire idle_w = core_ctl_out.enable && core_ready_in && rdy_ff && !busy_ff
      && !core_ctl_out.start;
   wire [2:0] age_inc = (age_ff == 3'h7) ? 3'h7 : age_ff + 3'h1;
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         sel_ff <= 16'h0000;
         tsel_ff <= 16'h0000;
         main_ff <= 32'h0000_0000;
         sec_ff <= 32'h0000_0000;
         ie_ff <= 7'h00;
         busy_ff <= 1'b0;
         rdy_ff <= 1'b0;
         age_ff <= 3'h7;
      end else begin
         if (wr_in && addr_in == OFS_TRIGGER_SELECT) sel_ff <= wdata_in[15:0];
         if (wr_main) main_ff <= wdata_in;
         if (wr_in && addr_in == OFS_SECOND_CONTROL) sec_ff <= wdata_in;
         if (wr_ie) ie_ff <= wdata_in[6:0];
         tsel_ff <= trg_w & sel_ff;
         rdy_ff <= core_ready_in;
         busy_ff <= core_ctl_out.start || (busy_ff && !core_res_in.valid);
         age_ff <= (sw_go || trg_rise || core_res_in.valid) ? 3'h0 : age_inc;
      end
   end
   sequence s_trig_req;
      trg_rise && idle_w;
   endsequence
   sequence s_quiet_clear;
      clr_all && !core_res_in.valid ##1 !core_res_in.valid;
   endsequence
   chk_sw_start: assert property (sw_go && idle_w |=> core_ctl_out.start)
      else $error("software start not answered");
   chk_trig_start: assert property (s_trig_req |-> ##[1:4] core_ctl_out.start)
      else $error("enabled trigger did not start");
   chk_start_cause: assert property (core_ctl_out.start |-> age_ff <= 3'h4)
      else $error("start without request");
   chk_start_once: assert property (core_ctl_out.start |=> !core_ctl_out.start)
      else $error("start longer than one cycle");
   chk_sel_readback: assert property (rd_in && addr_in == OFS_TRIGGER_SELECT
      |=> rdata_out == {16'h0000, sel_ff})
      else $error("trigger select readback wrong");
   chk_ie_gate: assert property (wr_ie && wdata_in[6:0] == 7'h00 ##1 !wr_ie
      |=> !irq_out)
      else $error("irq with all enables off");
   chk_clear_all: assert property (s_quiet_clear |=> !irq_out)
      else $error("irq after clearing all flags");
   chk_done_irq: assert property (core_res_in.valid && busy_ff && ie_ff[FLG_CONV_DONE]
      |-> ##[1:2] irq_out)
      else $error("no irq after enabled conversion done");
   chk_ctl_levels: assert property (!$past(wr_main)
      |-> core_ctl_out.temp_sensor_on == main_ff[TEMP_SENSOR_ENABLE_BIT]
      && core_ctl_out.follower_on == main_ff[FOLLOWER_ENABLE_BIT]
      && core_ctl_out.enable == main_ff[CONV_ENABLE_BIT])
      else $error("control levels differ from main control");
   chk_ctl_channel: assert property (core_ctl_out.start
      && main_ff[MODE_LSB +: 3] == MODE_SINGLE |-> core_ctl_out.channel == sec_ff[3:0])
      else $error("single mode channel wrong");
endmodule // adc_ctl_chk

bind adc_ctl adc_ctl_chk i_chk (.mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .dma_irq_in(dma_irq_in), .i2c_irq_in(i2c_irq_in), .spi_irq_in(spi_irq_in),
   .uart_irq_in(uart_irq_in), .basic_timer_irq_in(basic_timer_irq_in),
   .general_timer_irq_in(general_timer_irq_in), .advanced_timer_trig_in(advanced_timer_trig_in),
   .core_ready_in(core_ready_in), .core_res_in(core_res_in), .core_ctl_out(core_ctl_out),
   .irq_out(irq_out));

// ===== verif/conv_core_model.sv
`timescale 1ns/1ps
module conv_core_model
   import adc_ctl_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic srst_in,
   // From the block and the bench
   input wire conv_ctl_s ctl_in,
   input wire logic [11:0] value_in,
   input wire logic [3:0] lat_in,
   // Towards the block and the bench
   output logic ready_out,
   output conv_res_s res_out,
   output logic [7:0] starts_out
);
   logic [3:0] warm_ff;
   logic [4:0] cnt_ff;
   always_ff @(posedge mclk_in) begin
      if (srst_in || !ctl_in.enable) begin
         warm_ff <= 4'h0;
         ready_out <= 1'b0;
      end else begin
         if (warm_ff != 4'hF) warm_ff <= warm_ff + 4'h1;
         ready_out <= warm_ff > 4'h4;
      end
   end
   always_ff @(posedge mclk_in) begin
      res_out.valid <= 1'b0;
      // Idle data toggles so a stale sample never passes for a result
      res_out.data <= ~res_out.data;
      if (srst_in) begin
         cnt_ff <= 5'h00;
         starts_out <= 8'h00;
         res_out.data <= 12'h5A5;
      end else if (ctl_in.start) begin
         cnt_ff <= {1'b0, lat_in} + 5'h01;
         starts_out <= starts_out + 8'h01;
      end else if (cnt_ff == 5'h01) begin
         res_out.valid <= 1'b1;
         res_out.data <= value_in;
         cnt_ff <= 5'h00;
      end else if (cnt_ff != 5'h00) begin
         cnt_ff <= cnt_ff - 5'h01;
      end
   end
endmodule // conv_core_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import adc_ctl_pkg::*;
   logic mclk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0000_0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [15:0] trg = 16'h0000;
   logic [11:0] value = 12'h000;
   logic [3:0] lat = 4'h1;
   logic [31:0] rdata_out;
   logic core_ready_in;
   logic irq_out;
   logic [7:0] starts;
   conv_res_s core_res_in;
   conv_ctl_s core_ctl_out;
   int num_errors = 0;
   int num_checks = 0;
   int seed = 32'h70f4;
   always #25 mclk_in = ~mclk_in;
   adc_ctl i_dut (.mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .dma_irq_in(trg[15]), .i2c_irq_in(trg[14:13]), .spi_irq_in(trg[12:11]),
      .uart_irq_in(trg[10:8]), .basic_timer_irq_in(trg[7:5]),
      .general_timer_irq_in(trg[4:1]), .advanced_timer_trig_in(trg[0]),
      .core_ready_in(core_ready_in), .core_res_in(core_res_in),
      .core_ctl_out(core_ctl_out), .irq_out(irq_out));
   conv_core_model i_core (.mclk_in(mclk_in), .srst_in(srst_in), .ctl_in(core_ctl_out),
      .value_in(value), .lat_in(lat), .ready_out(core_ready_in), .res_out(core_res_in),
      .starts_out(starts));
   task automatic test_done();
      if (num_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, e, input string n);
      logic [31:0] d;
      rd(a, d);
      check(n, e, d & m);
   endtask
   task automatic wait_flag(input int b);
      logic [31:0] d = 32'h0000_0000;
      for (int i = 0; i < 40 && d[b] !== 1'b1; i++) rd(OFS_INT_STATUS, d);
      check("status flag", 32'h1, {31'h0, d[b]});
   endtask
   task automatic conv(input logic [11:0] v, input logic clr, input int b);
      if (clr) wr(OFS_INT_CLEAR, 32'h0000_0000);
      value <= v;
      wr(OFS_START, 32'h0000_0001);
      wait_flag(b);
   endtask
   // Order matches status bits 5..3
   function automatic logic [2:0] wd_exp(input logic [11:0] v, lo, hi);
      return {v >= lo && v < hi, v >= hi, v < lo};
   endfunction
   task automatic run_count(input logic [31:0] mode, input int b);
      logic [7:0] s0;
      wr(OFS_MAIN_CONTROL, mode);
      wr(OFS_INT_CLEAR, 32'h0000_0000);
      s0 = starts;
      wr(OFS_START, 32'h0000_0001);
      wait_flag(b);
      check("run starts", {24'h0, s0 + 8'h03}, {24'h0, starts});
   endtask
   initial begin
      #1_000_000;
      num_errors++;
      test_done();
   end
   initial begin
      logic [31:0] d;
      logic [11:0] lo, hi, v;
      logic [11:0] corner [6];
      logic [6:0] ie, e;
      logic [2:0] wd;
      repeat (2) @(posedge mclk_in);
      srst_in <= 1'b0;
      rdc(OFS_MAIN_CONTROL, 32'hFFFF_FFFF, 32'h0, "main reset");
      rdc(OFS_HIGH_THRESHOLD, 32'hFFF, {20'h0, HIGH_THRESHOLD_RESET}, "high reset");
      rdc(OFS_LOW_THRESHOLD, 32'hFFF, {20'h0, LOW_THRESHOLD_RESET}, "low reset");
      rdc(OFS_TRIGGER_SELECT, 32'hFFFF_FFFF, 32'h0, "select reset");
      rdc(8'h44, 32'hFFFF_FFFF, READ_ZERO, "unmapped");
      wr(OFS_MAIN_CONTROL, 32'h0000_0001);
      wait_flag(STARTUP_DONE_BIT);
      wr(OFS_MAIN_CONTROL, 32'h0000_2021);
      d = $random(seed);
      lo = {1'b0, d[10:0]};
      d = $random(seed);
      hi = lo + {1'b0, d[10:0]};
      wr(OFS_HIGH_THRESHOLD, {20'h0, hi});
      wr(OFS_LOW_THRESHOLD, {20'h0, lo});
      corner = '{lo - 12'h1, lo, hi - 12'h1, hi, RESULT_MAX, 12'h000};
      for (int k = 0; k < 24; k++) begin
         d = $random(seed);
         v = k < 6 ? corner[k] : d[11:0];
         ie = d[22:16] & 7'h39;
         lat <= d[27:24];
         wr(OFS_INT_ENABLE, {25'h0, ie});
         wr(OFS_SECOND_CONTROL, k == 7 ? 32'h0EE : (k == 8 ? 32'h1DE : 32'h1EE));
         conv(v, 1'b1, FLG_CONV_DONE);
         wd = (k == 7 || k == 8) ? 3'b000 : wd_exp(v, lo, hi);
         e = {1'b0, wd, 3'b001};
         rdc(OFS_INT_STATUS, 32'h79, {25'h0, e}, "status");
         rdc(OFS_FIRST_RESULT, 32'hFFF, {20'h0, v}, "result");
         check("irq", {31'h0, |(e & ie)}, {31'h0, irq_out});
      end
      conv(v, 1'b0, FLG_OVERFLOW);
      wr(OFS_INT_CLEAR, 32'hFFFF_FFBF);
      rdc(OFS_INT_STATUS, 32'h41, 32'h01, "clear one");
      wr(OFS_INT_ENABLE, 32'h0000_0000);
      for (int k = 0; k < TRIG_COUNT; k++) begin
         wr(OFS_TRIGGER_SELECT, 32'h1 << k);
         rdc(OFS_TRIGGER_SELECT, 32'hFFFF_FFFF, 32'h1 << k, "select");
         wr(OFS_INT_CLEAR, 32'h0000_0000);
         d[7:0] = starts;
         trg <= 16'h1 << ((k + 1) % TRIG_COUNT);
         repeat (6) @(posedge mclk_in);
         #1 check("masked source", {24'h0, d[7:0]}, {24'h0, starts});
         @(posedge mclk_in) trg <= 16'h1 << k;
         wait_flag(FLG_CONV_DONE);
         check("one start", {24'h0, d[7:0] + 8'h01}, {24'h0, starts});
         @(posedge mclk_in) trg <= 16'h0000;
      end
      wr(OFS_TRIGGER_SELECT, 32'h0000_0000);
      lat <= 4'h2;
      wr(OFS_SEQUENCE, 32'h0002_0321);
      run_count(32'h0000_2023, FLG_SEQ_DONE);
      wr(OFS_RUN_CONTROL, 32'h0000_0002);
      run_count(32'h0000_2025, FLG_ALL_DONE);
      wr(OFS_MAIN_CONTROL, 32'h0000_2029);
      wr(OFS_START, 32'h0000_0001);
      repeat (20) @(posedge mclk_in);
      rdc(OFS_START, 32'h1, 32'h1, "running");
      wr(OFS_START, 32'h0000_0000);
      rdc(OFS_START, 32'h1, 32'h0, "stopped");
      test_done();
   end
endmodule // tb_top
